// ---- verilog/eew_pkg.sv ----
/*
 * package for the host-side write/read controller of a self-timed parallel eeprom.
 * assumes a 200 MHz system clock; times given in ns (write cycle in us) and converted to cycles here.
 */
package eew_pkg;
    localparam int CLK_PERIOD_PS         = 5000;
    // strobe and data timing, in ns; write cycle in us
    localparam int STROBE_WIDTH_NS       = 100;
    localparam int DATA_SETUP_TIME_NS    = 50;
    localparam int DATA_HOLD_TIME_NS     = 10;
    localparam int DATA_VALID_WINDOW_NS  = 1000;
    localparam int ADDR_SETUP_NS         = 10;
    localparam int READ_ACCESS_NS        = 250;
    localparam int WRITE_CYCLE_DURATION_US = 5000;
    // least times round up, window (a longest time) rounds down
    localparam int STROBE_CYC  = (STROBE_WIDTH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SETUP_CYC   = (DATA_SETUP_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int HOLD_CYC    = (DATA_HOLD_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int DV_CYC      = (DATA_VALID_WINDOW_NS * 1000) / CLK_PERIOD_PS;
    localparam int ASU_CYC     = (ADDR_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int ACCESS_CYC  = (READ_ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // product taken in 64 bits: the write cycle in ps overflows an int
    localparam int WC_CYC      = int'((longint'(WRITE_CYCLE_DURATION_US) * 64'd1000000
                                 + longint'(CLK_PERIOD_PS) - 64'd1) / longint'(CLK_PERIOD_PS));
    // pin bundle driven toward the memory
    typedef struct packed {
        logic        ce_n;
        logic        we_n;
        logic        oe_n;
        logic [12:0] addr;
        logic [7:0]  dq;
        logic        dq_oe;
    } eew_pins_s;
endpackage

// ---- verilog/eew_host.sv ----
/*
 * host controller: turns single-cycle read and write requests into byte-wide
 * parallel bus cycles on a self-timed eeprom, then waits out its write cycle.
 * assumes dq_i comes from the pins (synchronised here) and the memory keeps its own timing.
 */
`timescale 1ns/1ps
module eew_host #(
    parameter int ADDR_W    = 13,
    parameter int WC_CYCLES = eew_pkg::WC_CYC
) (
    // clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // user request
    input  wire logic              req_i,
    input  wire logic              we_i,
    input  wire logic              page_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [7:0]        wdata_i,
    output logic                   ready_o,
    output logic                   rvalid_o,
    output logic [7:0]             rdata_o,
    output logic                   busy_o,
    // memory pins
    input  wire logic [7:0]        dq_i,
    output eew_pkg::eew_pins_s     pins_o
);
    // refuse parameters the pin bundle or counter cannot serve
    if (ADDR_W != 13 || WC_CYCLES < 1) begin : g_bad_param
        $error("eew_host: unsupported parameters");
    end

    typedef enum logic [6:0] {
        ST_IDLE  = 7'b0000001,
        ST_ASU   = 7'b0000010,
        ST_WLOW  = 7'b0000100,
        ST_WHOLD = 7'b0001000,
        ST_RACC  = 7'b0010000,
        ST_PAGE  = 7'b0100000,
        ST_WC    = 7'b1000000
    } eew_state_e;

    eew_state_e  state;
    logic [31:0] cnt;
    logic        wr_op;
    logic [7:0]  dq_s1;
    logic [7:0]  dq_s2;

    // timing figures, as counts of cycles
    localparam logic [31:0] STROBE = 32'(eew_pkg::STROBE_CYC);
    localparam logic [31:0] HOLD   = 32'(eew_pkg::HOLD_CYC);
    localparam logic [31:0] ASU    = 32'(eew_pkg::ASU_CYC);
    localparam logic [31:0] ACC    = 32'(eew_pkg::ACCESS_CYC + 2);
    localparam logic [31:0] WCC    = 32'(WC_CYCLES);

    // the strobe stays far inside the data-valid window, so setup suffices
    if (eew_pkg::STROBE_CYC >= eew_pkg::DV_CYC) begin : g_bad_strobe
        $error("eew_host: strobe exceeds window");
    end

    // two-flop synchroniser on read data
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            dq_s1 <= 8'h00;
            dq_s2 <= 8'h00;
        end else begin
            dq_s1 <= dq_i;
            dq_s2 <= dq_s1;
        end
    end

    // sequencer; new requests only in idle or page-open states
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state    <= ST_IDLE;
            cnt      <= 32'h0;
            wr_op    <= 1'b0;
            pins_o   <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: 13'h0, dq: 8'h00,
                          dq_oe: 1'b0};
            rvalid_o <= 1'b0;
            rdata_o  <= 8'h00;
        end else begin
            rvalid_o <= 1'b0;
            cnt      <= cnt + 32'h1;
            unique case (state)
                ST_IDLE, ST_PAGE: begin
                    if (req_i && (state == ST_IDLE || we_i)) begin
                        // address and data both set up before the strobe falls
                        pins_o.addr  <= addr_i;
                        pins_o.dq    <= wdata_i;
                        pins_o.dq_oe <= we_i;
                        pins_o.ce_n  <= 1'b0;
                        wr_op        <= we_i;
                        cnt          <= 32'h0;
                        state        <= ST_ASU;
                    end else if (state == ST_PAGE && cnt >= STROBE) begin
                        // page closes: memory's timers run out and programming starts
                        pins_o.ce_n <= 1'b1;
                        cnt         <= 32'h0;
                        state       <= ST_WC;
                    end
                end
                ST_ASU: begin
                    if (cnt + 32'h1 >= ASU) begin
                        cnt <= 32'h0;
                        if (wr_op) begin
                            pins_o.we_n <= 1'b0;
                            state       <= ST_WLOW;
                        end else begin
                            pins_o.oe_n <= 1'b0;
                            state       <= ST_RACC;
                        end
                    end
                end
                ST_WLOW: begin
                    // pulse held only for its least width, well inside the window
                    if (cnt + 32'h1 >= STROBE) begin
                        pins_o.we_n <= 1'b1;
                        cnt         <= 32'h0;
                        state       <= ST_WHOLD;
                    end
                end
                ST_WHOLD: begin
                    if (cnt + 32'h1 >= HOLD) begin
                        pins_o.dq_oe <= 1'b0;
                        pins_o.ce_n  <= 1'b1;
                        cnt          <= 32'h0;
                        state        <= page_i ? ST_PAGE : ST_WC;
                    end
                end
                ST_RACC: begin
                    if (cnt + 32'h1 >= ACC) begin
                        rdata_o     <= dq_s2;
                        rvalid_o    <= 1'b1;
                        pins_o.oe_n <= 1'b1;
                        pins_o.ce_n <= 1'b1;
                        state       <= ST_IDLE;
                    end
                end
                ST_WC: begin
                    // memory alters cells on its own; keep off the bus meanwhile
                    if (cnt + 32'h1 >= WCC) begin
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // handshake outputs
    assign ready_o = (state == ST_IDLE) || (state == ST_PAGE && we_i);
    assign busy_o  = (state != ST_IDLE);
endmodule

// ---- tb/eew_host_sva.sv ----
/* port checker for eew_host; bound to every eew_host instance below */
`timescale 1ns/1ps
module eew_host_sva #(parameter int WC_CYCLES = 50) (
    // watched ports
    input wire logic               clk_i,
    input wire logic               rst_i,
    input wire logic               req_i,
    input wire logic               we_i,
    input wire logic               ready_o,
    input wire logic               rvalid_o,
    input wire logic               busy_o,
    input wire eew_pkg::eew_pins_s pins_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_wstart;
        req_i && ready_o && we_i && !busy_o |-> ##[2:3] $fell(pins_o.we_n);
    endproperty
    a_wstart: assert property (p_wstart) else $error("strobe late");
    property p_wsel; $fell(pins_o.we_n) |-> !pins_o.ce_n && pins_o.dq_oe && pins_o.oe_n; endproperty
    a_wsel: assert property (p_wsel) else $error("strobe without data");
    property p_wlen; $fell(pins_o.we_n) |-> ##19 !pins_o.we_n ##1 pins_o.we_n; endproperty
    a_wlen: assert property (p_wlen) else $error("strobe width");
    property p_lat; !pins_o.we_n |-> $stable(pins_o.addr) && $stable(pins_o.dq); endproperty
    a_lat: assert property (p_lat) else $error("address or data moved");
    property p_hold; $rose(pins_o.we_n) |-> (pins_o.dq_oe && $stable(pins_o.dq))[*2]; endproperty
    a_hold: assert property (p_hold) else $error("data hold");
    property p_rd; req_i && ready_o && !we_i |-> ##[54:55] rvalid_o; endproperty
    a_rd: assert property (p_rd) else $error("read late");
    property p_rv; rvalid_o |=> !rvalid_o; endproperty
    a_rv: assert property (p_rv) else $error("rvalid long");
    property p_wc; $fell(pins_o.dq_oe) |-> busy_o[*8]; endproperty
    a_wc: assert property (p_wc) else $error("write cycle cut");
    property p_bus; pins_o.dq_oe |-> pins_o.oe_n; endproperty
    a_bus: assert property (p_bus) else $error("bus fight");
endmodule
bind eew_host eew_host_sva #(.WC_CYCLES(WC_CYCLES)) u_sva (.clk_i(clk_i), .rst_i(rst_i),
    .req_i(req_i), .we_i(we_i), .ready_o(ready_o), .rvalid_o(rvalid_o), .busy_o(busy_o),
    .pins_o(pins_o));

// ---- tb/eew_mem.sv ----
/* behavioural self-timed eeprom; assumes host pins as packed by eew_pkg */
`timescale 1ns/1ps
module eew_mem #(parameter int WC = 50) (
    input wire logic               clk_i,
    input wire eew_pkg::eew_pins_s pins_i,
    output logic [7:0]             dq_o
);
    logic [7:0]  mem [0:8191];
    logic [7:0]  last = 8'h00;
    logic [12:0] a;
    int          t = 0;
    // address latch, timer start and restart on falling strobe
    always @(negedge pins_i.we_n) if (!pins_i.ce_n) begin
        a = pins_i.addr;
        t = WC + 30;
    end
    // data latch, held inside for the whole alteration
    always @(posedge pins_i.we_n) if (!pins_i.ce_n) mem[a] = pins_i.dq;
    always @(posedge clk_i) if (t > 0) t = t - 1;
    // rom-like read; pins give inverted last value while programming, deselected or output-disabled
    assign dq_o = (!pins_i.ce_n && !pins_i.oe_n && t == 0) ? mem[pins_i.addr] : ~last;
    always @(posedge clk_i) last <= dq_o;
endmodule

// ---- tb/eew_host_tb_top.sv ----
/* self-checking bench for eew_host; memory model on its pins */
`timescale 1ns/1ps
module eew_host_tb_top;
    logic clk_i = 0, rst_i = 1, req_i = 0, we_i = 0, page_i = 0, ready_o, rvalid_o, busy_o;
    logic [12:0] addr_i = 13'h0000;
    logic [7:0]  wdata_i = 8'h00, rdata_o, dq_i;
    eew_pkg::eew_pins_s pins_o;
    int err_total = 0, checks_done = 0, n;
    eew_host #(.WC_CYCLES(50)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .req_i(req_i), .we_i(we_i),
        .page_i(page_i), .addr_i(addr_i), .wdata_i(wdata_i), .ready_o(ready_o),
        .rvalid_o(rvalid_o), .rdata_o(rdata_o), .busy_o(busy_o), .dq_i(dq_i), .pins_o(pins_o));
    eew_mem #(.WC(50)) u_mem (.clk_i(clk_i), .pins_i(pins_o), .dq_o(dq_i));
    always #2.5 clk_i = ~clk_i;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic step; @(posedge clk_i); #1; n++; endtask
    // one request, entered and left 1 ns after an edge
    task automatic xfer(input logic w, input logic [12:0] a, input logic [7:0] d, input logic p);
        n = 0;
        we_i = w; addr_i = a; wdata_i = d; page_i = p;
        while (ready_o !== 1'b1 && n < 500) step;
        req_i = 1;
        step;
        req_i = 0;
    endtask
    task automatic idle;
        n = 0;
        while (busy_o !== 1'b0 && n < 900) step;
        if (busy_o !== 1'b0) begin
            err_total++;
            $display("BAD %0t still busy", $time);
        end
    endtask
    task automatic rd(input logic [12:0] a, input logic [7:0] e);
        xfer(0, a, 8'h00, 0);
        n = 0;
        while (rvalid_o !== 1'b1 && n < 99) step;
        chk(rdata_o, e);
    endtask
    task automatic t_reset; chk({4'h0, ready_o, busy_o, pins_o.ce_n, pins_o.we_n}, 8'h0B); endtask
    task automatic t_single;
        xfer(1, 13'h1FFF, 8'hA5, 0);
        idle;
        chk({7'h00, n >= 70}, 8'h01);
        rd(13'h1FFF, 8'hA5);
    endtask
    task automatic t_page;
        xfer(1, 13'h000A, 8'h3C, 1);
        repeat (27) step;
        chk({7'h00, ready_o}, 8'h01);
        we_i = 0;
        step;
        chk({7'h00, ready_o}, 8'h00);
        xfer(1, 13'h000B, 8'hC3, 0);
        idle;
        rd(13'h000A, 8'h3C);
        rd(13'h000B, 8'hC3);
    endtask
    task automatic complete_run;
        if (err_total == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk_i);
        #1 rst_i = 0;
        t_reset;
        t_single;
        t_page;
        complete_run;
    end
    initial begin
        #100000;
        err_total++;
        complete_run;
    end
endmodule
